/* File: hdl/xsd_defs.vh */
`ifndef XSD_DEFS_VH
`define XSD_DEFS_VH

// ==========================================================
// register byte offsets (AHB-Lite, one word each)
`define XSD_OFF_CTRL     8'h00
`define XSD_OFF_INSTR    8'h04
`define XSD_OFF_WORK     8'h08
`define XSD_OFF_BANK     8'h0C
`define XSD_OFF_PTR0     8'h10
`define XSD_OFF_PTR1     8'h14
`define XSD_OFF_PTR2     8'h18
`define XSD_OFF_PC       8'h1C
`define XSD_OFF_PCHI     8'h20
`define XSD_OFF_PCUP     8'h24
`define XSD_OFF_STATUS   8'h28
`define XSD_OFF_STKPTR   8'h2C
`define XSD_OFF_MEMADDR  8'h30
`define XSD_OFF_MEMDATA  8'h34

// ==========================================================
// reset values
`define XSD_RST_EXT      1'b1
`define XSD_RST_BYTE     8'h00
`define XSD_RST_PTR      12'h000
`define XSD_RST_PC       21'h000000
`define XSD_RST_INSTR    16'h0000

// ==========================================================
// field positions
`define XSD_CTRL_EXT     0
`define XSD_ST_Z         2
`define XSD_ST_N         4
`define XSD_INSTR_BUSY   16
`define XSD_INSTR_WAIT2  17

// ==========================================================
// opcodes
`define XSD_OP_XOR6      6'b000110
`define XSD_OP_PADD      8'hE8
`define XSD_OP_PSUB      8'hE9
`define XSD_OP_PUSH_LIT  8'hEA
`define XSD_OP_MOVS      8'hEB
`define XSD_OP_CALL_WORK 16'h0014
`define XSD_OP_SECOND    4'hF
`define XSD_SEL_RET      2'b11

// ==========================================================
// addressing constants
`define XSD_IDX_LIMIT    8'h5F
`define XSD_ACC_SPLIT    8'h80
`define XSD_ACC_LOW_BANK 4'h0
`define XSD_ACC_HI_BANK  4'hF
`define XSD_PC_STEP1     21'h000002
`define XSD_PC_STEP2     21'h000004
`define XSD_PTR_DEC      12'h001

`endif

/* File: hdl/xsd_dmem.v */
`timescale 1ns/1ps
// ==========================================================
// data memory, registered read
module xsd_dmem #(
    parameter AW = 12,
    parameter DW = 8
) (
    input  wire          clk,     // system clock
    input  wire [AW-1:0] raddr,   // read address
    output reg  [DW-1:0] rdata,   // read data, one clock late
    input  wire          we,      // write strobe
    input  wire [AW-1:0] waddr,   // write address
    input  wire [DW-1:0] wdata    // write data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

/* File: hdl/xsd_hwstack.v */
`timescale 1ns/1ps
// ==========================================================
// hardware return stack
module xsd_hwstack #(
    parameter DEPTH = 31,
    parameter PW    = 5,
    parameter DW    = 21
) (
    input  wire          clk,     // system clock
    input  wire          rst,     // async reset, active high
    input  wire          push,    // push request
    input  wire          pop,     // pop request
    input  wire [DW-1:0] din,     // value pushed
    output wire [DW-1:0] head,    // current top of stack
    output reg  [PW-1:0] ptr_r    // number of entries held
);
    reg [DW-1:0] ent [0:DEPTH-1];

    // full push and empty pop are dropped, not wrapped
    assign head = (ptr_r == {PW{1'b0}}) ? {DW{1'b0}} : ent[ptr_r - 1'b1];

    always @(posedge clk) begin
        if (push && ptr_r < DEPTH[PW-1:0]) begin
            ent[ptr_r] <= din;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr_r <= {PW{1'b0}};
        end else if (push && ptr_r < DEPTH[PW-1:0]) begin
            ptr_r <= ptr_r + 1'b1;
        end else if (pop && ptr_r != {PW{1'b0}}) begin
            ptr_r <= ptr_r - 1'b1;
        end
    end
endmodule

/* File: hdl/xsd_core.v */
`timescale 1ns/1ps
`include "xsd_defs.vh"
module xsd_core #(
    parameter STACK_DEPTH = 31,
    parameter MEM_AW      = 12
) (
    input  wire        clk,        // 125 MHz system clock
    input  wire        rst,        // async reset, active high
    input  wire        hsel,       // slave select
    input  wire [31:0] haddr,      // byte address
    input  wire [1:0]  htrans,     // transfer type
    input  wire        hwrite,     // write when high
    input  wire [2:0]  hsize,      // transfer size, word only
    input  wire [31:0] hwdata,     // write data
    input  wire        hready,     // bus ready in
    output wire        hreadyout,  // slave ready out
    output wire        hresp,      // always OKAY
    output reg  [31:0] hrdata      // read data, registered
);
    // ==========================================================
    // quarter-phase states
    localparam S_IDLE  = 6'b000001;
    localparam S_WAIT2 = 6'b000010;
    localparam S_Q1    = 6'b000100;
    localparam S_Q2    = 6'b001000;
    localparam S_Q3    = 6'b010000;
    localparam S_Q4    = 6'b100000;
    reg [5:0]        state_r;
    reg              cyc2_r;
    reg [15:0]       ir_r;
    reg [15:0]       ir2_r;
    reg [7:0]        work_r;
    reg [3:0]        bank_r;
    reg [11:0]       ptr0_r;
    reg [11:0]       ptr1_r;
    reg [11:0]       ptr2_r;
    reg [20:0]       pc_r;
    reg [7:0]        pchi_r;
    reg [4:0]        pcup_r;
    reg              neg_r;
    reg              zero_r;
    reg              ext_r;
    reg [MEM_AW-1:0] memaddr_r;
    reg [7:0]        alu_r;
    reg              dph_r;
    reg              dwr_r;
    reg [7:0]        daddr_r;
    wire [7:0]  mem_rd;
    wire [20:0] stk_head;
    wire [4:0]  stk_ptr;
    // ==========================================================
    // helpers
    function [11:0] file_addr;
        input [7:0]  f;
        input        a;
        input        ext;
        input [3:0]  bank;
        input [11:0] p2;
        begin
            if (a) begin
                file_addr = {bank, f};
            end else if (ext && f <= `XSD_IDX_LIMIT) begin
                file_addr = p2 + {4'h0, f};
            end else if (f < `XSD_ACC_SPLIT) begin
                file_addr = {`XSD_ACC_LOW_BANK, f};
            end else begin
                file_addr = {`XSD_ACC_HI_BANK, f};
            end
        end
    endfunction

    function [11:0] idx_addr;
        input [11:0] p2;
        input [6:0]  off;
        begin
            idx_addr = p2 + {5'h00, off};
        end
    endfunction

    // ==========================================================
    // decode
    wire       is_xor  = (ir_r[15:10] == `XSD_OP_XOR6);
    wire       is_padd = ext_r && (ir_r[15:8] == `XSD_OP_PADD);
    wire       is_psub = ext_r && (ir_r[15:8] == `XSD_OP_PSUB);
    wire       is_push = ext_r && (ir_r[15:8] == `XSD_OP_PUSH_LIT);
    wire       is_movs = ext_r && (ir_r[15:8] == `XSD_OP_MOVS);
    wire       is_call = ext_r && (ir_r == `XSD_OP_CALL_WORK);
    wire       is_ret  = (is_padd || is_psub) && (ir_r[7:6] == `XSD_SEL_RET);
    wire       two_cyc = is_ret || is_call || is_movs;
    wire [5:0] lit6    = ir_r[5:0];
    wire [11:0] f_addr = file_addr(ir_r[7:0], ir_r[8], ext_r, bank_r, ptr2_r);
    wire [11:0] src_addr = idx_addr(ptr2_r, ir_r[6:0]);
    wire [11:0] dst_addr = ir_r[7] ? idx_addr(ptr2_r, ir2_r[6:0]) : ir2_r[11:0];
    wire [7:0]  xor_res  = work_r ^ mem_rd;
    wire        last_q4  = (state_r == S_Q4) && (cyc2_r || !two_cyc);
    wire        exec     = (state_r != S_IDLE) && (state_r != S_WAIT2);
    wire [11:0] ptr_sel  = (ir_r[7:6] == 2'b00) ? ptr0_r : (ir_r[7:6] == 2'b01) ? ptr1_r : ptr2_r;
    wire [11:0] ptr_new  = is_padd ? ptr_sel + {6'h00, lit6} : ptr_sel - {6'h00, lit6};
    // ==========================================================
    // bus slave
    wire acc     = hsel && htrans[1] && hready;
    wire stall   = dph_r && dwr_r && exec;
    wire bus_wr  = dph_r && dwr_r && !stall;
    assign hreadyout = !stall;
    assign hresp     = 1'b0;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dph_r   <= 1'b0;
            dwr_r   <= 1'b0;
            daddr_r <= `XSD_RST_BYTE;
        end else if (hready || !dph_r) begin
            dph_r   <= acc;
            dwr_r   <= acc && hwrite;
            daddr_r <= haddr[7:0];
        end
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (acc && !hwrite) begin
            if (haddr[7:0] == `XSD_OFF_CTRL) begin
                hrdata <= {31'h00000000, ext_r};
            end else if (haddr[7:0] == `XSD_OFF_INSTR) begin
                hrdata <= {14'h0000, state_r == S_WAIT2, exec, ir_r};
            end else if (haddr[7:0] == `XSD_OFF_WORK) begin
                hrdata <= {24'h000000, work_r};
            end else if (haddr[7:0] == `XSD_OFF_BANK) begin
                hrdata <= {28'h0000000, bank_r};
            end else if (haddr[7:0] == `XSD_OFF_PTR0) begin
                hrdata <= {20'h00000, ptr0_r};
            end else if (haddr[7:0] == `XSD_OFF_PTR1) begin
                hrdata <= {20'h00000, ptr1_r};
            end else if (haddr[7:0] == `XSD_OFF_PTR2) begin
                hrdata <= {20'h00000, ptr2_r};
            end else if (haddr[7:0] == `XSD_OFF_PC) begin
                hrdata <= {11'h000, pc_r};
            end else if (haddr[7:0] == `XSD_OFF_PCHI) begin
                hrdata <= {24'h000000, pchi_r};
            end else if (haddr[7:0] == `XSD_OFF_PCUP) begin
                hrdata <= {27'h0000000, pcup_r};
            end else if (haddr[7:0] == `XSD_OFF_STATUS) begin
                hrdata <= {27'h0000000, neg_r, 1'b0, zero_r, 2'b00};
            end else if (haddr[7:0] == `XSD_OFF_STKPTR) begin
                hrdata <= {27'h0000000, stk_ptr};
            end else if (haddr[7:0] == `XSD_OFF_MEMADDR) begin
                hrdata <= {{(32-MEM_AW){1'b0}}, memaddr_r};
            end else if (haddr[7:0] == `XSD_OFF_MEMDATA) begin
                hrdata <= {24'h000000, mem_rd};
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

    // ==========================================================
    // memory and stack ports
    reg              mem_we;
    reg [MEM_AW-1:0] mem_wa;
    reg [7:0]        mem_wd;
    reg [MEM_AW-1:0] mem_ra;
    reg              stk_push;
    reg              stk_pop;

    always @* begin
        mem_we   = 1'b0;
        mem_wa   = memaddr_r;
        mem_wd   = hwdata[7:0];
        mem_ra   = memaddr_r;
        stk_push = 1'b0;
        stk_pop  = 1'b0;
        if (bus_wr && daddr_r == `XSD_OFF_MEMDATA) begin
            mem_we = 1'b1;
        end
        if (exec) begin
            mem_ra = is_movs ? src_addr : f_addr;
        end
        if (state_r == S_Q4) begin
            if (is_xor && ir_r[9]) begin
                mem_we = 1'b1;
                mem_wa = f_addr;
                mem_wd = alu_r;
            end else if (is_push) begin
                mem_we = 1'b1;
                mem_wa = ptr2_r;
                mem_wd = ir_r[7:0];
            end else if (is_movs && cyc2_r) begin
                mem_we = 1'b1;
                mem_wa = dst_addr;
                mem_wd = alu_r;
            end
            // call pushes in cycle one; return pops in cycle two
            stk_push = is_call && !cyc2_r;
            stk_pop  = is_ret && cyc2_r;
        end
    end

    xsd_dmem #(
        .AW    (MEM_AW),
        .DW    (8)
    ) u_dmem (
        .clk   (clk),
        .raddr (mem_ra),
        .rdata (mem_rd),
        .we    (mem_we),
        .waddr (mem_wa),
        .wdata (mem_wd)
    );

    xsd_hwstack #(
        .DEPTH (STACK_DEPTH),
        .PW    (5),
        .DW    (21)
    ) u_stack (
        .clk   (clk),
        .rst   (rst),
        .push  (stk_push),
        .pop   (stk_pop),
        .din   (pc_r + `XSD_PC_STEP1),
        .head  (stk_head),
        .ptr_r (stk_ptr)
    );

    // ==========================================================
    // sequencer and architectural registers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r   <= S_IDLE;
            cyc2_r    <= 1'b0;
            ir_r      <= `XSD_RST_INSTR;
            ir2_r     <= `XSD_RST_INSTR;
            work_r    <= `XSD_RST_BYTE;
            bank_r    <= 4'h0;
            ptr0_r    <= `XSD_RST_PTR;
            ptr1_r    <= `XSD_RST_PTR;
            ptr2_r    <= `XSD_RST_PTR;
            pc_r      <= `XSD_RST_PC;
            pchi_r    <= `XSD_RST_BYTE;
            pcup_r    <= 5'h00;
            neg_r     <= 1'b0;
            zero_r    <= 1'b0;
            ext_r     <= `XSD_RST_EXT;
            memaddr_r <= {MEM_AW{1'b0}};
            alu_r     <= `XSD_RST_BYTE;
        end else begin
            if (bus_wr) begin
                if (daddr_r == `XSD_OFF_CTRL) begin
                    ext_r <= hwdata[`XSD_CTRL_EXT];
                end else if (daddr_r == `XSD_OFF_WORK) begin
                    work_r <= hwdata[7:0];
                end else if (daddr_r == `XSD_OFF_BANK) begin
                    bank_r <= hwdata[3:0];
                end else if (daddr_r == `XSD_OFF_PTR0) begin
                    ptr0_r <= hwdata[11:0];
                end else if (daddr_r == `XSD_OFF_PTR1) begin
                    ptr1_r <= hwdata[11:0];
                end else if (daddr_r == `XSD_OFF_PTR2) begin
                    ptr2_r <= hwdata[11:0];
                end else if (daddr_r == `XSD_OFF_PC) begin
                    pc_r <= hwdata[20:0];
                end else if (daddr_r == `XSD_OFF_PCHI) begin
                    pchi_r <= hwdata[7:0];
                end else if (daddr_r == `XSD_OFF_PCUP) begin
                    pcup_r <= hwdata[4:0];
                end else if (daddr_r == `XSD_OFF_STATUS) begin
                    neg_r  <= hwdata[`XSD_ST_N];
                    zero_r <= hwdata[`XSD_ST_Z];
                end else if (daddr_r == `XSD_OFF_MEMADDR) begin
                    memaddr_r <= hwdata[MEM_AW-1:0];
                end
            end
            case (state_r)
                S_IDLE: begin
                    if (bus_wr && daddr_r == `XSD_OFF_INSTR) begin
                        ir_r   <= hwdata[15:0];
                        cyc2_r <= 1'b0;
                        // two-word move waits for its second word
                        if (ext_r && hwdata[15:8] == `XSD_OP_MOVS) begin
                            state_r <= S_WAIT2;
                        end else begin
                            state_r <= S_Q1;
                        end
                    end
                end
                S_WAIT2: begin
                    if (bus_wr && daddr_r == `XSD_OFF_INSTR) begin
                        ir2_r   <= hwdata[15:0];
                        state_r <= S_Q1;
                    end
                end
                S_Q1: begin
                    state_r <= S_Q2;
                end
                S_Q2: begin
                    state_r <= S_Q3;
                end
                S_Q3: begin
                    if (is_xor) begin
                        alu_r <= xor_res;
                    end else if (is_movs && !cyc2_r) begin
                        alu_r <= mem_rd;
                    end
                    state_r <= S_Q4;
                end
                S_Q4: begin
                    if (is_xor) begin
                        neg_r  <= alu_r[7];
                        zero_r <= (alu_r == `XSD_RST_BYTE);
                        if (!ir_r[9]) begin
                            work_r <= alu_r;
                        end
                    end
                    if (!cyc2_r) begin
                        if (is_ret) begin
                            ptr2_r <= ptr_new;
                        end else if (is_padd || is_psub) begin
                            if (ir_r[7:6] == 2'b00) begin
                                ptr0_r <= ptr_new;
                            end else if (ir_r[7:6] == 2'b01) begin
                                ptr1_r <= ptr_new;
                            end else begin
                                ptr2_r <= ptr_new;
                            end
                        end else if (is_push) begin
                            ptr2_r <= ptr2_r - `XSD_PTR_DEC;
                        end
                    end
                    if (last_q4) begin
                        state_r <= S_IDLE;
                        cyc2_r  <= 1'b0;
                        if (is_ret) begin
                            pc_r <= stk_head;
                        end else if (is_call) begin
                            pc_r <= {pcup_r, pchi_r, work_r};
                        end else if (is_movs) begin
                            pc_r <= pc_r + `XSD_PC_STEP2;
                        end else begin
                            pc_r <= pc_r + `XSD_PC_STEP1;
                        end
                    end else begin
                        state_r <= S_Q1;
                        cyc2_r  <= 1'b1;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: verif/xsd_core_assertions.sv */
`timescale 1ns/1ps
// ==========================================
// bus-side checker
module xsd_core_assertions (
    input wire        clk,       // system clock
    input wire        rst,       // async reset
    input wire        hsel,      // select
    input wire [31:0] haddr,     // address
    input wire [1:0]  htrans,    // transfer type
    input wire        hwrite,    // direction
    input wire [31:0] hwdata,    // write data
    input wire        hready,    // bus ready
    input wire        hreadyout, // slave ready
    input wire        hresp,     // response
    input wire [31:0] hrdata     // read data
);
    reg       rd_r;
    reg       wr_r;
    reg       one_r;
    reg [7:0] a_r;
    wire      take = hsel & htrans[1] & hready;
    // one_r: last opcode written should finish in a single cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_r  <= 1'b0;
            wr_r  <= 1'b0;
            one_r <= 1'b0;
            a_r   <= 8'h00;
        end else begin
            if (hready) begin
                rd_r <= take & ~hwrite;
                wr_r <= take & hwrite;
                if (take)
                    a_r <= haddr[7:0];
            end
            if (wr_r && hready && a_r == 8'h04)
                one_r <= hwdata[15:10] == 6'h06 || hwdata[15:8] == 8'hEA ||
                         (hwdata[15:9] == 7'h74 && hwdata[7:6] != 2'h3);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
    a_read_nowait: assert property (rd_r |-> hreadyout) else $error("read stalled");
    a_stall_write: assert property (!hreadyout |-> wr_r) else $error("bad stall");
    a_rdata_hold: assert property (!rd_r |-> $stable(hrdata))
        else $error("read data moved");
    a_short_stall: assert property (one_r && !hreadyout |-> ##[1:4] hreadyout)
        else $error("one cycle op too long");
    a_long_stall: assert property (!hreadyout |-> ##[1:9] hreadyout)
        else $error("two cycle op too long");
    a_status_bits: assert property (rd_r && a_r == 8'h28 |-> (hrdata & ~32'h14) == 0)
        else $error("stray status bits");
    a_work_narrow: assert property (rd_r && a_r == 8'h08 |-> hrdata[31:8] == 0)
        else $error("working register wide");
    c_instr_read: cover property (rd_r && a_r == 8'h04);
    c_short: cover property (!hreadyout && one_r);
    c_long: cover property (!hreadyout && !one_r);
endmodule
bind xsd_core xsd_core_assertions u_chk (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

/* File: verif/xsd_ahb_master.sv */
`timescale 1ns/1ps
// ==========================================
// bus master, single whole-word transfers
module xsd_ahb_master (
    input  wire        clk,            // system clock
    input  wire        hready,         // bus ready
    input  wire [31:0] hrdata,         // read data
    output reg         hsel = 1'b1,    // select
    output reg  [31:0] haddr = 32'h0,  // address
    output reg  [1:0]  htrans = 2'h0,  // transfer type
    output reg         hwrite = 1'b0,  // direction
    output reg  [2:0]  hsize = 3'h2,   // word
    output reg  [31:0] hwdata = 32'h0  // write data
);
    task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
        @(posedge clk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (!hready) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (!hready) @(posedge clk);
        q = hrdata;
    endtask
endmodule

/* File: verif/xsd_core_tb.sv */
`timescale 1ns/1ps
// ==========================================
// core testbench
module xsd_core_tb;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    wire        hsel, hwrite, hreadyout, hresp;
    wire [31:0] haddr, hwdata, hrdata;
    wire [1:0]  htrans;
    wire [2:0]  hsize;
    integer     err_count = 0;
    integer     total_checks = 0;
    integer     i;
    reg  [1:0]  sel;
    reg  [31:0] rv = 32'hF76B;
    reg  [31:0] v, p;
    always #4 clk = ~clk;
    xsd_core u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    xsd_ahb_master m (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [31:0] flags(input [7:0] r);
        flags = {27'h0, r[7], 1'b0, r == 8'h00, 2'h0};
    endfunction
    task check(input [31:0] s, input [31:0] e);
        total_checks = total_checks + 1;
        if (s !== e) begin
            err_count = err_count + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        m.xfer(1'b1, a, d, v);
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        m.xfer(1'b0, a, 32'h0, v);
        check(v, e);
    endtask
    // trailing write stalls until the opcode has retired, except after the first word of a two-word move
    task exec(input [15:0] op);
        wr(8'h04, {16'h0, op});
        wr(8'h30, 32'h0);
    endtask
    task memc(input [11:0] a, input [7:0] e);
        wr(8'h30, {20'h0, a});
        rdc(8'h34, {24'h0, e});
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200000;
        err_count = err_count + 1;
        test_done;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdc(8'h00, 32'h1);
        rdc(8'hFC, 32'h0);
        for (i = 0; i < 8; i = i + 1) begin
            rv = lfsr(rv);
            p = {20'h0, rv[27:24], rv[7:0]};
            wr(8'h18, p);
            exec({8'hEA, rv[15:8]});
            rdc(8'h18, (p - 1) & 32'hFFF);
            wr(8'h08, {24'h0, rv[23:16]});
            wr(8'h0C, {28'h0, rv[27:24]});
            exec({6'h06, rv[28], 1'b1, rv[7:0]});
            if (rv[28])
                memc(p[11:0], rv[15:8] ^ rv[23:16]);
            rdc(8'h08, rv[28] ? rv[23:16] : rv[15:8] ^ rv[23:16]);
            rdc(8'h28, flags(rv[15:8] ^ rv[23:16]));
        end
        $display("xor test done");
        wr(8'h18, 32'h200);
        exec(16'hEA5A);
        wr(8'h18, 32'h1A1);
        wr(8'h08, 32'h0F);
        exec(16'h1A5F);
        memc(12'h200, 8'h55);
        exec(16'hEB5F);
        exec(16'hF300);
        memc(12'h300, 8'h55);
        exec(16'hEBDF);
        exec(16'hF07F);
        memc(12'h220, 8'h55);
        $display("indexed test done");
        for (i = 0; i < 6; i = i + 1) begin
            rv = lfsr(rv);
            sel = i % 3;
            wr(8'h10 + 4 * sel, rv[11:0]);
            exec({7'h74, i > 2, sel, rv[21:16]});
            rdc(8'h10 + 4 * sel, (i > 2 ? rv[11:0] - rv[21:16] : rv[11:0] + rv[21:16])
                & 32'hFFF);
        end
        $display("pointer test done");
        wr(8'h20, 32'h12);
        wr(8'h24, 32'h03);
        wr(8'h08, 32'h46);
        m.xfer(1'b0, 8'h1C, 32'h0, p);
        exec(16'h0014);
        rdc(8'h1C, 32'h031246);
        rdc(8'h2C, 32'h1);
        wr(8'h18, 32'h100);
        exec(16'hE8C5);
        rdc(8'h18, 32'h105);
        rdc(8'h1C, p + 2);
        exec(16'h0014);
        exec(16'hE9C5);
        rdc(8'h18, 32'h100);
        rdc(8'h1C, p + 4);
        wr(8'h00, 32'h0);
        wr(8'h10, 32'h10);
        exec(16'hE805);
        rdc(8'h10, 32'h10);
        $display("call test done");
        test_done;
    end
endmodule
